// ### design/spi_slave_pkg.sv
// Constants and decode helpers shared by the serial port slave logic.
// Assumes a single system clock domain; all users reference it by scope.
package spi_slave_pkg;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int COUNT_W = 3;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_LAST = 3'h7;
  localparam logic [BYTE_BITS-1:0] BYTE_RESET = 8'h00;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // Select line timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SELECT_SETUP_NS = 16;
  localparam int SELECT_SETUP_CYCLES =
    (SELECT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Select line modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEL_THREE_WIRE,
    SEL_FOUR_WIRE_IN,
    SEL_FOUR_WIRE_OUT
  } sel_mode_t;

  function automatic sel_mode_t decode_sel_mode(input logic hi, input logic lo);
    if (hi) begin
      return SEL_FOUR_WIRE_OUT;
    end else if (lo) begin
      return SEL_FOUR_WIRE_IN;
    end
    return SEL_THREE_WIRE;
  endfunction : decode_sel_mode

endpackage : spi_slave_pkg

// ### design/shift_link_if.sv
// Carrier between the port control logic and the byte shifter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface shift_link_if;
  logic sample_edge;
  logic shift_edge;
  logic mosi;
  logic clear;
  logic load;
  logic [spi_slave_pkg::BYTE_BITS-1:0] load_byte;
  logic done;
  logic [spi_slave_pkg::BYTE_BITS-1:0] rx_word;
  logic miso;
  logic tx_full;
  logic [spi_slave_pkg::COUNT_W-1:0] count;

  modport ctrl (
    output sample_edge, shift_edge, mosi, clear, load, load_byte,
    input done, rx_word, miso, tx_full, count
  );
  modport shift (
    input sample_edge, shift_edge, mosi, clear, load, load_byte,
    output done, rx_word, miso, tx_full, count
  );
endinterface : shift_link_if

// ### design/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes inputs are independent levels; no bus coherence is implied.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] sync_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          stage1[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          stage1[g] <= pin_i[g];
          sync_o[g] <= stage1[g];
        end
      end
    end
  endgenerate
endmodule : pin_sync

// ### design/byte_shifter.sv
// Byte shifter: receive and transmit shift registers with bit counter.
// Assumes edge strobes are one-cycle pulses from the control block.
`timescale 1ns/1ps
module byte_shifter (
  input wire logic clk_i,
  input wire logic rst_i,
  shift_link_if.shift lnk
);
  logic [spi_slave_pkg::BYTE_BITS-1:0] rx;
  logic [spi_slave_pkg::BYTE_BITS-1:0] tx;

  assign lnk.done = lnk.sample_edge && !lnk.clear &&
    (lnk.count == spi_slave_pkg::COUNT_LAST);
  assign lnk.rx_word = {rx[spi_slave_pkg::BYTE_BITS-2:0], lnk.mosi};
  assign lnk.miso = tx[spi_slave_pkg::BYTE_BITS-1];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lnk.count <= spi_slave_pkg::COUNT_RESET;
      rx <= spi_slave_pkg::BYTE_RESET;
    end else if (lnk.clear) begin
      // Partial byte dropped, no completion
      lnk.count <= spi_slave_pkg::COUNT_RESET;
      rx <= spi_slave_pkg::BYTE_RESET;
    end else if (lnk.sample_edge) begin
      lnk.count <= lnk.count + 3'h1;
      rx <= lnk.rx_word;
    end
  end

  // Transmit side: advances only inside a byte, never on the first edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx <= spi_slave_pkg::BYTE_RESET;
      lnk.tx_full <= 1'b0;
    end else if (lnk.load) begin
      tx <= lnk.load_byte;
      lnk.tx_full <= 1'b1;
    end else begin
      if (lnk.shift_edge && !lnk.clear && lnk.count != spi_slave_pkg::COUNT_RESET) begin
        tx <= {tx[spi_slave_pkg::BYTE_BITS-2:0], 1'b0};
      end
      if (lnk.done) begin
        lnk.tx_full <= 1'b0;
      end
    end
  end
endmodule : byte_shifter

// ### design/spi_slave_port.sv
// Serial port slave logic with slave-select mode handling.
// Assumes control bits come from software registers on clk_i and that
// the link pins are asynchronous and pass through pin_sync.
`timescale 1ns/1ps

// What this block does
// - Mode high bit set: select pin driven out
// - Driven select level follows mode low bit
// - Enabled, not master: act as slave
// - Count edges; eight bits set done, buffer byte
// - Data port read returns receive buffer
// - Slave never starts a transfer itself
// - Data port writes land in transmit buffer
// - Empty shift register loads buffer at once
// - Busy shift register loads after last edge
// - Mode 0,1 slave: select pin is input
// - Four-wire slave active only while select low
// - Select falling edge clears bit counter
// - Mode 0,0 slave: select pin ignored
// - Three-wire counter cleared only by disable or master set
// - Multi-master select low: fault, disable port
// - Received bits enter most significant first
// - Done flag raises interrupt when enabled
// - Three-wire master ignores select pin
module spi_slave_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic serial_port_enable_bit_i,
  input wire logic master_enable_bit_i,
  input wire logic slave_select_mode_hi_i,
  input wire logic slave_select_mode_lo_i,
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic interrupt_enable_i,
  input wire logic data_write_i,
  input wire logic [7:0] data_write_byte_i,
  output logic [7:0] serial_data_port_o,
  output logic transfer_done_flag_o,
  input wire logic transfer_done_clear_i,
  output logic mode_fault_flag_o,
  input wire logic mode_fault_clear_i,
  output logic port_disable_request_o,
  output logic tx_buffer_busy_o,
  output logic irq_o,
  input wire logic sck_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic slave_select_pin_i,
  output logic slave_select_pin_o,
  output logic slave_select_oe_n_o
);

  // ----------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------
  logic [2:0] pins_sync;
  logic sck_s;
  logic mosi_s;
  logic select_s;
  logic sck_d;
  logic select_d;

  pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({sck_i, mosi_i, !slave_select_pin_i}),
    .sync_o(pins_sync)
  );

  assign sck_s = pins_sync[2];
  assign mosi_s = pins_sync[1];
  // Select carried inverted: the zero reset of the synchroniser then reads
  // as deselected, so no drive and no false select edge after reset
  assign select_s = !pins_sync[0];

  // Select idles high so a deselected bus gives no false falling edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d <= 1'b0;
      select_d <= 1'b1;
    end else begin
      sck_d <= sck_s;
      select_d <= select_s;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic select_fall;
  logic leading_edge;
  logic trailing_edge;

  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  assign select_fall = !select_s && select_d;
  assign leading_edge = clock_polarity_i ? sck_fall : sck_rise;
  assign trailing_edge = clock_polarity_i ? sck_rise : sck_fall;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  spi_slave_pkg::sel_mode_t sel_mode;
  logic slave_mode;
  logic four_wire_slave;
  logic three_wire_slave;
  logic slave_active;
  logic fault_event;

  assign sel_mode = spi_slave_pkg::decode_sel_mode(slave_select_mode_hi_i,
    slave_select_mode_lo_i);
  assign slave_mode = serial_port_enable_bit_i && !master_enable_bit_i;
  assign four_wire_slave = slave_mode &&
    (sel_mode == spi_slave_pkg::SEL_FOUR_WIRE_IN);
  assign three_wire_slave = slave_mode &&
    (sel_mode == spi_slave_pkg::SEL_THREE_WIRE);
  // Three-wire slave has no select; must be alone on the bus
  assign slave_active = three_wire_slave ||
    (four_wire_slave && !select_s);
  assign fault_event = serial_port_enable_bit_i && master_enable_bit_i &&
    (sel_mode == spi_slave_pkg::SEL_FOUR_WIRE_IN) && !select_s;

  // ----------------------------------------
  // Shifter control
  // ----------------------------------------
  shift_link_if lnk ();

  byte_shifter u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk)
  );

  logic [7:0] tx_buffer;
  logic tx_buffer_valid;

  // Edges only count while active: three-wire slave, or four-wire slave selected by an outside master
  // Select setup of two clocks covers the two-stage sync lag
  assign lnk.sample_edge = slave_active &&
    (clock_phase_i ? trailing_edge : leading_edge);
  assign lnk.shift_edge = slave_active &&
    (clock_phase_i ? leading_edge : trailing_edge);
  assign lnk.mosi = mosi_s;
  // Only leaving slave mode (enable low or master set) clears a three-wire counter
  assign lnk.clear = !slave_mode ||
    (four_wire_slave && select_fall);
  assign lnk.load = tx_buffer_valid && !lnk.tx_full;
  assign lnk.load_byte = tx_buffer;

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  // A write in a load cycle keeps the new byte pending
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_buffer <= spi_slave_pkg::BYTE_RESET;
      tx_buffer_valid <= 1'b0;
    end else if (data_write_i) begin
      tx_buffer <= data_write_byte_i;
      tx_buffer_valid <= 1'b1;
    end else if (lnk.load) begin
      tx_buffer_valid <= 1'b0;
    end
  end

  assign tx_buffer_busy_o = tx_buffer_valid;

  // ----------------------------------------
  // Receive buffer and flags
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_data_port_o <= spi_slave_pkg::BYTE_RESET;
    end else if (lnk.done) begin
      serial_data_port_o <= lnk.rx_word;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      transfer_done_flag_o <= 1'b0;
    end else if (lnk.done) begin
      transfer_done_flag_o <= 1'b1;
    end else if (transfer_done_clear_i) begin
      transfer_done_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_fault_flag_o <= 1'b0;
    end else if (fault_event) begin
      mode_fault_flag_o <= 1'b1;
    end else if (mode_fault_clear_i) begin
      mode_fault_flag_o <= 1'b0;
    end
  end

  // Software-side register clears enable and master bits on this pulse
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_disable_request_o <= 1'b0;
    end else begin
      port_disable_request_o <= fault_event;
    end
  end

  assign irq_o = interrupt_enable_i &&
    (transfer_done_flag_o || mode_fault_flag_o);

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  assign miso_o = lnk.miso;
  assign miso_oe_n_o = !slave_active;

  // Select pin is an output whenever the mode high bit is set, master or slave
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slave_select_pin_o <= 1'b1;
      slave_select_oe_n_o <= 1'b1;
    end else begin
      slave_select_pin_o <= slave_select_mode_lo_i;
      slave_select_oe_n_o <= !slave_select_mode_hi_i;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_select_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(slave_select_mode_hi_i) |-> !slave_select_oe_n_o)
    else $error("select pin not driven in four-wire master mode");

  a_select_level: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(slave_select_mode_hi_i) |-> slave_select_pin_o == $past(slave_select_mode_lo_i))
    else $error("driven select level does not follow mode low bit");

  a_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.done |=> transfer_done_flag_o && serial_data_port_o == $past(lnk.rx_word))
    else $error("completed byte not flagged or not buffered");

  a_eight_edges: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.done |-> lnk.count == 3'h7 && lnk.sample_edge)
    else $error("completion not on the eighth sample edge");

  a_no_self_start: assert property (@(posedge clk_i) disable iff (rst_i)
    !slave_active && !lnk.clear |=> $stable(lnk.count))
    else $error("shift activity while not selected");

  a_load_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    data_write_i && !tx_buffer_valid && !lnk.tx_full && !lnk.done |-> ##2 lnk.tx_full)
    else $error("write to empty shifter not loaded at once");

  a_load_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.tx_full && lnk.done && tx_buffer_valid |=> lnk.load)
    else $error("pending byte not loaded after last edge");

  a_hold_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.tx_full && !lnk.done |=> lnk.tx_full)
    else $error("shifter released before its byte completed");

  a_inactive_high: assert property (@(posedge clk_i) disable iff (rst_i)
    four_wire_slave && select_s |-> miso_oe_n_o)
    else $error("data output driven while deselected");

  a_select_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    four_wire_slave && select_fall |=> lnk.count == 3'h0)
    else $error("counter not cleared on select falling edge");

  a_three_wire: assert property (@(posedge clk_i) disable iff (rst_i)
    !slave_select_mode_hi_i [*2] |-> slave_select_oe_n_o)
    else $error("select pin driven outside four-wire master mode");

  a_disable_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !serial_port_enable_bit_i |=> lnk.count == 3'h0 && !lnk.done)
    else $error("disabled port not returned to idle");

  a_mode_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_event |=> mode_fault_flag_o && port_disable_request_o)
    else $error("mode fault not flagged");

  a_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    lnk.done && interrupt_enable_i |=> irq_o)
    else $error("no interrupt after completed byte");

  a_three_wire_count: assert property (@(posedge clk_i) disable iff (rst_i)
    three_wire_slave && !lnk.sample_edge |=> $stable(lnk.count))
    else $error("three-wire counter changed without an edge");

  a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    transfer_done_clear_i && !lnk.done |=> !transfer_done_flag_o)
    else $error("done flag not cleared");

  a_fault_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_fault_clear_i && !fault_event |=> !mode_fault_flag_o)
    else $error("mode fault flag not cleared");

endmodule : spi_slave_port

// ### bench/spi_master_model.sv
// External serial master model: clock, data and select driven from delays.
// Assumes the bench sets polarity and phase before each frame; 80 ns link period.
`timescale 1ns/1ps
module spi_master_model (
  input wire logic pol_i,
  input wire logic phase_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic mosi_o,
  output logic slave_select_pin_o
);
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    slave_select_pin_o = 1'b1;
  end

  task automatic set_sel(input logic v);
    slave_select_pin_o = v;
  endtask : set_sel

  // ----------------------------------------
  // One frame of nbits, most significant first
  // ----------------------------------------
  task automatic xfer(input logic [7:0] tx, input int nbits, input logic use_sel,
                      output logic [7:0] rx);
    rx = 8'h00;
    // Idle level settles before select, so a polarity change is no edge
    sck_o = pol_i;
    #40;
    if (use_sel) begin
      slave_select_pin_o = 1'b0;
    end
    // Without select the port must be the only slave on the bus
    #40;
    for (int i = 7; i > 7 - nbits; i--) begin
      if (!phase_i) begin
        mosi_o = tx[i];
      end
      #40 sck_o = ~pol_i;
      if (phase_i) begin
        mosi_o = tx[i];
      end else begin
        rx[i] = miso_i;
      end
      #40 sck_o = pol_i;
      if (phase_i) begin
        rx[i] = miso_i;
      end
    end
    // Released data line shows no stale bit
    #40 mosi_o = ~mosi_o;
    if (use_sel) begin
      slave_select_pin_o = 1'b1;
    end
    #40;
  endtask : xfer
endmodule : spi_master_model

// ### bench/test_spi_slave_port.sv
// Self-checking bench for the serial port slave: select modes, framing, buffering.
// Assumes spi_master_model drives the link pins and a 125 MHz system clock.
`timescale 1ns/1ps
module test_spi_slave_port;
  logic clk, rst, enable, master, mode_hi, mode_lo, pol, phase, irq_en;
  logic wr, done_clr, fault_clr, done_q, sck, mosi, sel_m, sel_w, sel_o, sel_oe_n;
  logic miso, miso_oe_n, miso_w, done, fault, disable_req, busy, irq;
  logic [7:0] wr_byte, got, a, b, rx_buf;
  logic [7:0] exp_q[$];
  int mismatches, tests_run;

  assign sel_w = sel_oe_n ? sel_m : sel_o;
  assign miso_w = miso_oe_n ? ~miso : miso;

  spi_slave_port dut_u (
    .clk_i(clk), .rst_i(rst), .serial_port_enable_bit_i(enable),
    .master_enable_bit_i(master), .slave_select_mode_hi_i(mode_hi),
    .slave_select_mode_lo_i(mode_lo), .clock_polarity_i(pol), .clock_phase_i(phase),
    .interrupt_enable_i(irq_en), .data_write_i(wr), .data_write_byte_i(wr_byte),
    .serial_data_port_o(rx_buf), .transfer_done_flag_o(done),
    .transfer_done_clear_i(done_clr), .mode_fault_flag_o(fault),
    .mode_fault_clear_i(fault_clr), .port_disable_request_o(disable_req),
    .tx_buffer_busy_o(busy), .irq_o(irq), .sck_i(sck), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .slave_select_pin_i(sel_w), .slave_select_pin_o(sel_o),
    .slave_select_oe_n_o(sel_oe_n)
  );

  spi_master_model m_u (
    .pol_i(pol), .phase_i(phase), .miso_i(miso_w), .sck_o(sck), .mosi_o(mosi),
    .slave_select_pin_o(sel_m)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic conclude();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic write_tx(input logic [7:0] v);
    wr = 1'b1;
    wr_byte = v;
    tick(1);
    wr = 1'b0;
  endtask : write_tx

  // Frame from the master; received byte is noted for the monitor
  task automatic send(input logic [7:0] m, input logic [7:0] e, input logic chk);
    int n;
    n = 0;
    exp_q.push_back(m);
    m_u.xfer(m, 8, mode_lo, got);
    tick(1);
    if (chk) begin
      check(got, e);
    end
    while (done !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      conclude();
    end
    check({7'h00, irq}, {7'h00, irq_en});
    done_clr = 1'b1;
    tick(1);
    done_clr = 1'b0;
    tick(1);
    check({7'h00, done}, 8'h00);
  endtask : send

  // ----------------------------------------
  // Monitor: each new done flag takes the oldest note
  // ----------------------------------------
  always @(negedge clk) begin
    if (done === 1'b1 && done_q !== 1'b1) begin
      if (exp_q.size() == 0) begin
        exp_q.push_back(8'hxx);
      end
      check(rx_buf, exp_q.pop_front());
    end
    done_q = done;
  end

  initial begin
    rst = 1'b1;
    enable = 1'b1;
    master = 1'b0;
    mode_hi = 1'b0;
    mode_lo = 1'b1;
    pol = 1'b0;
    phase = 1'b0;
    irq_en = 1'b1;
    wr = 1'b0;
    wr_byte = 8'h00;
    done_clr = 1'b0;
    fault_clr = 1'b0;
    done_q = 1'b0;
    mismatches = 0;
    tests_run = 0;
    a = 8'($urandom(10698));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(3);
    check({7'h00, sel_oe_n}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      pol = k[1];
      phase = k[0];
      a = 8'($urandom);
      b = 8'($urandom);
      write_tx(a);
      check({7'h00, busy}, 8'h01);
      tick(1);
      check({7'h00, busy}, 8'h00);
      tick(20);
      check({7'h00, done}, 8'h00);
      send(b, a, 1'b1);
    end
    pol = 1'b0;
    phase = 1'b0;
    write_tx(a);
    tick(1);
    write_tx(b);
    tick(1);
    check({7'h00, busy}, 8'h01);
    send(8'h3c, a, 1'b1);
    send(8'hc3, b, 1'b1);
    m_u.xfer(8'hff, 8, 1'b0, got);
    tick(6);
    check({6'h00, done, miso_oe_n}, 8'h01);
    m_u.xfer(8'h55, 3, 1'b1, got);
    tick(1);
    send(b, 8'h00, 1'b0);
    // Three-wire: select stays high and must not matter
    mode_lo = 1'b0;
    tick(3);
    check({7'h00, sel_oe_n}, 8'h01);
    m_u.xfer(8'h0f, 5, 1'b0, got);
    tick(6);
    check({7'h00, done}, 8'h00);
    enable = 1'b0;
    tick(2);
    enable = 1'b1;
    tick(4);
    write_tx(a);
    tick(1);
    send(b, a, 1'b1);
    master = 1'b1;
    mode_hi = 1'b1;
    for (int k = 0; k < 2; k++) begin
      mode_lo = k[0];
      tick(3);
      check({6'h00, sel_oe_n, sel_w}, {7'h00, k[0]});
    end
    mode_hi = 1'b0;
    mode_lo = 1'b0;
    m_u.set_sel(1'b0);
    tick(4);
    check({7'h00, fault}, 8'h00);
    mode_lo = 1'b1;
    tick(4);
    check({6'h00, fault, disable_req}, 8'h03);
    check({7'h00, irq}, 8'h01);
    enable = 1'b0;
    master = 1'b0;
    m_u.set_sel(1'b1);
    fault_clr = 1'b1;
    tick(1);
    fault_clr = 1'b0;
    tick(1);
    check({7'h00, fault}, 8'h00);
    conclude();
  end
endmodule : test_spi_slave_port
